/* hdl/mac_coll_pkg.sv */
// Purpose: shared constants for the collision statistics and mgmt status
//          register block.
// Assumes: AXI4-Lite register bus with 32-bit data, byte addressing.
// Notes:   each register page except the interrupt page holds base, clear, set and invert words.
package mac_coll_pkg;
   // address layout: bits [5:4] pick the page, bits [3:2] the alias op
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_COUNT = 8'h00; // multi_collision_frame_count
   localparam logic [7:0] OFS_CLRT = 8'h10; // collision_window_retry_limit
   localparam logic [7:0] OFS_MIND = 8'h20; // mgmt_link_indicators
   localparam logic [7:0] OFS_IRQ_STAT = 8'h30; // sticky events, write 1 clears
   localparam logic [7:0] OFS_IRQ_MASK = 8'h34; // interrupt enables
   localparam int PAGE_LSB = 4;
   localparam int OP_LSB = 2;
   localparam logic [1:0] PAGE_COUNT = 2'h0;
   localparam logic [1:0] PAGE_CLRT = 2'h1;
   localparam logic [1:0] PAGE_MIND = 2'h2;
   localparam logic [1:0] PAGE_IRQ = 2'h3;
   // alias operations at base plus 0x4, 0x8 and 0xc
   localparam logic [1:0] OP_STORE = 2'h0;
   localparam logic [1:0] OP_CLR = 2'h1;
   localparam logic [1:0] OP_SET = 2'h2;
   localparam logic [1:0] OP_INV = 2'h3;
   // collision window / retry limit fields
   localparam int CWIN_LSB = 8;
   localparam int CWIN_W = 6;
   localparam int RETRANSMIT_LIMIT_LSB = 0;
   localparam int RETRANSMIT_LIMIT_W = 4;
   localparam logic [5:0] CWIN_RESET = 6'h37; // 55 bytes incl. preamble/SFD
   localparam logic [3:0] RETRANSMIT_LIMIT_RESET = 4'hf;
   localparam int CNT_W = 16;
   // indicator bit positions
   localparam int IND_BUSY = 0;
   localparam int IND_SCAN = 1;
   localparam int IND_PEND = 2;
   localparam int IND_LINK = 3;
   localparam int IND_W = 4;
   // interrupt event bits
   localparam int EV_COUNT = 0;
   localparam int EV_ABORT = 1;
   localparam int EV_LINK = 2;
   localparam int EV_W = 3;
   // byte enable patterns accepted for writes
   localparam logic [3:0] STRB_WORD = 4'hf;
   localparam logic [3:0] STRB_LOW = 4'h3;
   localparam logic [3:0] STRB_HIGH = 4'hc;
   localparam logic [31:0] MASK_LOW = 32'h0000ffff;
   localparam logic [31:0] MASK_HIGH = 32'hffff0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mac_coll_pkg

/* hdl/mac_coll_mgmt_regs.sv */
// Purpose: collision statistics, back-off configuration and management
//          indicator registers of an Ethernet MAC, on an AXI4-Lite slave.
// Assumes: tx and management engine strobes are on CLOCK (50 MHz).
// Notes:   outputs all come from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module mac_coll_mgmt_regs
   import mac_coll_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic TX_MULTI_COLL_DONE,
   input wire logic TX_START,
   input wire logic TX_COLLISION,
   input wire logic PHY_STATUS_STROBE,
   input wire logic PHY_LINK_FAIL,
   input wire logic MGMT_READ_PENDING,
   input wire logic MGMT_SCAN_ACTIVE,
   input wire logic MGMT_ENGINE_BUSY,
   output logic [CWIN_W-1:0] COLLISION_WINDOW,
   output logic TX_RETRY,
   output logic TX_ABORT_EXCESS,
   output logic IRQ
);

   // byte lanes of a write; a single byte or odd mix gives no lanes
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      case (s)
         STRB_WORD: m = MASK_LOW | MASK_HIGH;
         STRB_LOW: m = MASK_LOW;
         STRB_HIGH: m = MASK_HIGH;
         default: m = '0;
      endcase
      return m;
   endfunction : strb_mask

   // store, clear, set or invert the lanes in m
   function automatic logic [31:0] alias_op(input logic [31:0] old,
      input logic [31:0] d, input logic [31:0] m, input logic [1:0] op);
      logic [31:0] r;
      r = old;
      case (op)
         OP_STORE: r = (old & ~m) | (d & m);
         OP_CLR: r = old & ~(d & m);
         OP_SET: r = old | (d & m);
         OP_INV: r = old ^ (d & m);
         default: r = old;
      endcase
      return r;
   endfunction : alias_op

   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic aw_held_reg, w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [CNT_W-1:0] count_reg, count_next;
   logic [CWIN_W-1:0] cwin_reg;
   logic [RETRANSMIT_LIMIT_W-1:0] retransmit_limit_reg, attempts_reg, attempts_next;
   logic [IND_W-1:0] ind_reg, ind_next;
   logic [EV_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, events;
   logic retry_reg, abort_reg, irq_reg;

   // write channel handshakes and the moment a write is performed
   wire aw_take = S_AXI_AWVALID & awready_reg;
   wire w_take = S_AXI_WVALID & wready_reg;
   wire do_wr = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire aw_held_next = (aw_held_reg | aw_take) & ~do_wr;
   wire w_held_next = (w_held_reg | w_take) & ~do_wr;
   wire bvalid_next = do_wr | (bvalid_reg & ~S_AXI_BREADY);
   wire [1:0] wr_page = awaddr_reg[PAGE_LSB +: 2];
   wire [1:0] wr_op = awaddr_reg[OP_LSB +: 2];
   wire wr_hit = (awaddr_reg[ADDR_W-1:PAGE_LSB+2] == '0) &&
                 (awaddr_reg[1:0] == 2'h0) &&
                 ((wr_page != PAGE_IRQ) || (wr_op[1] == 1'b0));
   wire [31:0] wmask = strb_mask(wstrb_reg);
   wire wr_count = do_wr & wr_hit & (wr_page == PAGE_COUNT);
   wire wr_clrt = do_wr & wr_hit & (wr_page == PAGE_CLRT);
   wire wr_mind = do_wr & wr_hit & (wr_page == PAGE_MIND);
   wire wr_istat = do_wr & wr_hit & (awaddr_reg[7:0] == OFS_IRQ_STAT);
   wire wr_imask = do_wr & wr_hit & (awaddr_reg[7:0] == OFS_IRQ_MASK);

   // read channel decode
   wire ar_take = S_AXI_ARVALID & arready_reg;
   wire rvalid_next = ar_take | (rvalid_reg & ~S_AXI_RREADY);
   wire [1:0] rd_page = S_AXI_ARADDR[PAGE_LSB +: 2];
   wire [1:0] rd_op = S_AXI_ARADDR[OP_LSB +: 2];
   wire rd_hit = (S_AXI_ARADDR[ADDR_W-1:PAGE_LSB+2] == '0) &&
                 (S_AXI_ARADDR[1:0] == 2'h0) &&
                 ((rd_page != PAGE_IRQ) || (rd_op[1] == 1'b0));
   wire [31:0] clrt_word = 32'(cwin_reg) << CWIN_LSB | 32'(retransmit_limit_reg);
   wire [31:0] rd_word =
      !rd_hit ? 32'h0 :
      (rd_page == PAGE_COUNT) ? 32'(count_reg) :
      (rd_page == PAGE_CLRT) ? clrt_word :
      (rd_page == PAGE_MIND) ? 32'(ind_reg) :
      (rd_op == 2'h0) ? 32'(irq_stat_reg) : 32'(irq_mask_reg);
   // AXI4-Lite reads always enable every byte, so lanes 0/1 are on
   wire rd_clear = ar_take & rd_hit & (rd_page == PAGE_COUNT);

   // count: software write, then clear on read, then increment
   wire [31:0] count_wr = alias_op(32'(count_reg), wdata_reg, wmask, wr_op);
   always_comb begin
      count_next = wr_count ? count_wr[CNT_W-1:0] : count_reg;
      if (rd_clear) begin
         count_next = '0;
      end
      if (TX_MULTI_COLL_DONE) begin
         count_next = count_next + 16'h0001;
      end
   end

   // configuration field updates through base or alias words
   wire [31:0] clrt_wr = alias_op(clrt_word, wdata_reg, wmask, wr_op);

   // retry tracking against the programmed limit
   wire at_limit = (attempts_reg >= retransmit_limit_reg);
   wire abort_now = TX_COLLISION & ~TX_START & at_limit;
   wire retry_now = TX_COLLISION & ~TX_START & ~at_limit;
   assign attempts_next = (TX_START | abort_now) ? '0 :
                          retry_now ? attempts_reg + 4'h1 : attempts_reg;

   // indicators follow the engine; link failure is the last PHY status or bus write, PHY status first
   wire [31:0] mind_wr = alias_op(32'(ind_reg), wdata_reg, wmask, wr_op);
   wire link_fail_next = PHY_STATUS_STROBE ? PHY_LINK_FAIL :
                         wr_mind ? mind_wr[IND_LINK] : ind_reg[IND_LINK];
   assign ind_next = {link_fail_next, MGMT_READ_PENDING, MGMT_SCAN_ACTIVE,
                      MGMT_ENGINE_BUSY};

   // sticky events; a new event wins over a write-one clear
   assign events = {link_fail_next & ~ind_reg[IND_LINK], abort_now,
                    TX_MULTI_COLL_DONE};
   wire [EV_W-1:0] istat_clr = wr_istat ? (wdata_reg[EV_W-1:0] &
                               wmask[EV_W-1:0]) : '0;
   assign irq_stat_next = (irq_stat_reg & ~istat_clr) | events;
   wire [31:0] imask_wr = alias_op(32'(irq_mask_reg), wdata_reg, wmask,
                                   OP_STORE);

   // bus handshake registers
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= ~aw_held_next & ~bvalid_next;
         wready_reg <= ~w_held_next & ~bvalid_next;
         bvalid_reg <= bvalid_next;
         if (do_wr) begin
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_take) begin
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // captured write address and data
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else begin
         if (aw_take) awaddr_reg <= S_AXI_AWADDR;
         if (w_take) begin
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
         end
      end
   end

   // register file and back-off state
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         count_reg <= '0;
         cwin_reg <= CWIN_RESET;
         retransmit_limit_reg <= RETRANSMIT_LIMIT_RESET;
         attempts_reg <= '0;
         ind_reg <= '0;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         count_reg <= count_next;
         if (wr_clrt) begin
            cwin_reg <= clrt_wr[CWIN_LSB +: CWIN_W];
            retransmit_limit_reg <= clrt_wr[RETRANSMIT_LIMIT_LSB +: RETRANSMIT_LIMIT_W];
         end
         attempts_reg <= attempts_next;
         ind_reg <= ind_next;
         irq_stat_reg <= irq_stat_next;
         if (wr_imask) irq_mask_reg <= imask_wr[EV_W-1:0];
      end
   end

   // registered outputs toward the transmit path and the interrupt line
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         retry_reg <= 1'b0;
         abort_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         retry_reg <= retry_now;
         abort_reg <= abort_now;
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY = wready_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign COLLISION_WINDOW = cwin_reg;
   assign TX_RETRY = retry_reg;
   assign TX_ABORT_EXCESS = abort_reg;
   assign IRQ = irq_reg;

   // checks on the register behaviour
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   a_count_increment: assert property (
      TX_MULTI_COLL_DONE && !wr_count && !rd_clear
      |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("count did not step on a multi-collision frame");
   a_count_wraps: assert property (
      TX_MULTI_COLL_DONE && !wr_count && !rd_clear && count_reg == 16'hffff
      |=> count_reg == 16'h0000)
      else $error("count did not wrap to zero");
   a_read_clears_count: assert property (
      rd_clear && !TX_MULTI_COLL_DONE
      |=> count_reg == 16'h0000 && rdata_reg[CNT_W-1:0] == $past(count_reg))
      else $error("read did not clear the count");
   a_alias_set_bits: assert property (
      wr_clrt && wr_op == OP_SET && (wmask & MASK_LOW) == MASK_LOW
      |=> retransmit_limit_reg == ($past(retransmit_limit_reg) | $past(wdata_reg[RETRANSMIT_LIMIT_LSB +: RETRANSMIT_LIMIT_W]))
      && cwin_reg == ($past(cwin_reg) | $past(wdata_reg[CWIN_LSB +: CWIN_W])))
      else $error("set alias did not set configuration bits");
   a_window_output: assert property (
      wr_clrt && wr_op == OP_STORE && wstrb_reg == STRB_WORD
      |=> COLLISION_WINDOW == $past(wdata_reg[CWIN_LSB +: CWIN_W]))
      else $error("collision window output does not follow the field");
   a_abort_at_limit: assert property (
      TX_COLLISION && !TX_START && attempts_reg >= retransmit_limit_reg
      |=> TX_ABORT_EXCESS && !TX_RETRY && attempts_reg == 4'h0)
      else $error("no abort at the retry limit");
   a_byte_write_ignored: assert property (
      do_wr && wmask == 32'h0 && !TX_MULTI_COLL_DONE && !rd_clear
      |=> $stable(count_reg))
      else $error("byte-wide write changed the count");
   a_byte_cfg_ignored: assert property (
      do_wr && wmask == 32'h0 |=> $stable(cwin_reg) && $stable(retransmit_limit_reg))
      else $error("byte-wide write changed the configuration");
   a_link_fail_capture: assert property (
      PHY_STATUS_STROBE |=> ind_reg[IND_LINK] == $past(PHY_LINK_FAIL))
      else $error("link failure not taken from the PHY status");
   a_pending_scan_busy: assert property (
      1'b1 |=> ind_reg[IND_W-2:0] == $past({MGMT_READ_PENDING,
               MGMT_SCAN_ACTIVE, MGMT_ENGINE_BUSY}))
      else $error("indicators do not follow the management engine");
   a_busy_readback: assert property (
      ar_take && rd_hit && rd_page == PAGE_MIND
      |=> S_AXI_RDATA[IND_BUSY] == $past(ind_reg[IND_BUSY]))
      else $error("busy bit not returned on read");
   a_upper_bits_zero: assert property (
      S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0)
      else $error("unimplemented bits read as nonzero");

   c_count_read: cover property (rd_clear ##1 S_AXI_RVALID);
   c_excess_abort: cover property (TX_ABORT_EXCESS);
   c_half_write: cover property (do_wr && wstrb_reg == STRB_LOW);
   c_irq_raised: cover property (!IRQ ##1 IRQ);

endmodule : mac_coll_mgmt_regs
`default_nettype wire

/* tb/mac_tx_mgmt_model.sv */
// Purpose: far-side model of the tx engine, PHY status and mgmt engine.
// Assumes: bench calls the tasks; lines change just after a rising edge.
// Notes: strobes last one cycle; released link level shows its inverse.
`timescale 1ns/1ps
`default_nettype none
module mac_tx_mgmt_model (
   input wire logic clock,
   input wire logic retry,
   input wire logic abort,
   output logic multi_done,
   output logic tx_start,
   output logic collision,
   output logic stat_strobe,
   output logic link_fail,
   output logic [2:0] mgmt_lvl
);
   // all lines idle at time zero
   initial begin
      multi_done = 1'b0;
      tx_start = 1'b0;
      collision = 1'b0;
      stat_strobe = 1'b0;
      link_fail = 1'b0;
      mgmt_lvl = 3'h0;
   end
   // one frame sent after more than one collision
   task automatic frame_done();
      @(posedge clock) multi_done <= 1'b1;
      @(posedge clock) multi_done <= 1'b0;
   endtask : frame_done
   // start of a new frame
   task automatic new_frame();
      @(posedge clock) tx_start <= 1'b1;
      @(posedge clock) tx_start <= 1'b0;
   endtask : new_frame
   // one collision, then report the back-off answer
   task automatic collide(output logic rt, output logic ab);
      @(posedge clock) collision <= 1'b1;
      @(posedge clock) collision <= 1'b0;
      #1;
      rt = retry;
      ab = abort;
   endtask : collide
   // a PHY status read completes with the given link state
   task automatic phy_status(input logic fail);
      @(posedge clock);
      stat_strobe <= 1'b1;
      link_fail <= fail;
      @(posedge clock);
      stat_strobe <= 1'b0;
      link_fail <= ~fail; // stale value no longer held
   endtask : phy_status
   // mgmt engine levels: bit 0 busy, bit 1 scan, bit 2 read pending
   task automatic mgmt(input logic [2:0] lv);
      @(posedge clock) mgmt_lvl <= lv;
   endtask : mgmt
endmodule : mac_tx_mgmt_model
`default_nettype wire

/* tb/mac_coll_mgmt_regs_test.sv */
// Purpose: self-checking bench for the collision and mgmt register block.
// Assumes: AXI4-Lite master tasks; far side given by mac_tx_mgmt_model.
// Notes: every wait is bounded; a timeout counts as a mismatch.
`timescale 1ns/1ps
`default_nettype none
module mac_coll_mgmt_regs_test
   import mac_coll_pkg::*;
;
   logic clock, rst_b, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, retry, abort, irq;
   logic [1:0] bresp, rresp;
   logic [5:0] cwin;
   logic mdone, txs, coll, strobe, lfail;
   logic [2:0] lvl;
   int n_fail, check_count;
   // block under test and its far side
   mac_coll_mgmt_regs mac_coll_mgmt_regs_i (.CLOCK(clock), .RST_B(rst_b),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .TX_MULTI_COLL_DONE(mdone), .TX_START(txs),
      .TX_COLLISION(coll), .PHY_STATUS_STROBE(strobe),
      .PHY_LINK_FAIL(lfail), .MGMT_READ_PENDING(lvl[2]),
      .MGMT_SCAN_ACTIVE(lvl[1]), .MGMT_ENGINE_BUSY(lvl[0]),
      .COLLISION_WINDOW(cwin), .TX_RETRY(retry), .TX_ABORT_EXCESS(abort),
      .IRQ(irq));
   mac_tx_mgmt_model mac_tx_mgmt_model_i (.clock(clock), .retry(retry),
      .abort(abort), .multi_done(mdone), .tx_start(txs), .collision(coll),
      .stat_strobe(strobe), .link_fail(lfail), .mgmt_lvl(lvl));
   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   // compare one value, count and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask : chk
   // a wait ran out
   task automatic tmo();
      $display("[ERR] t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
      n_fail++;
      test_done();
   endtask : tmo
   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      int i;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      r = bresp;
      if (i == 40) tmo();
   endtask : wr
   // read one word
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int i;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      if (i == 40) tmo();
   endtask : rd
   // read and compare, response must be OKAY
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
      chk(r, RESP_OKAY);
   endtask : rchk
   // write with the given strobes, response ignored
   task automatic ww(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic [1:0] r;
      wr(a, d, s, r);
   endtask : ww
   // values straight after reset
   task automatic t_reset();
      rchk(OFS_CLRT, 32'h0000370f);
      chk(cwin, 6'h37);
      rchk(OFS_COUNT, 32'h0);
      rchk(OFS_MIND, 32'h0);
   endtask : t_reset
   // counting, clear on read through base and alias, wrap
   task automatic t_count();
      repeat (3) mac_tx_mgmt_model_i.frame_done();
      rchk(OFS_COUNT, 32'h3);
      rchk(OFS_COUNT, 32'h0);
      mac_tx_mgmt_model_i.frame_done();
      rchk(OFS_COUNT + 8'h4, 32'h1);
      rchk(OFS_COUNT, 32'h0);
      ww(OFS_COUNT + 8'h8, 32'h0000ffff, STRB_WORD);
      mac_tx_mgmt_model_i.frame_done();
      rchk(OFS_COUNT, 32'h0);
   endtask : t_count
   // aliases, unimplemented bits, access widths
   task automatic t_alias();
      ww(OFS_CLRT, 32'hffffffff, STRB_WORD);
      rchk(OFS_CLRT, 32'h00003f0f);
      ww(OFS_CLRT + 8'h4, 32'h00003000, STRB_WORD);
      rchk(OFS_CLRT, 32'h00000f0f);
      ww(OFS_CLRT + 8'h8, 32'h00002000, STRB_LOW);
      ww(OFS_CLRT + 8'hc, 32'h00000105, STRB_WORD);
      rchk(OFS_CLRT, 32'h00002e0a);
      chk(cwin, 6'h2e);
      ww(OFS_CLRT, 32'h0, 4'h1);
      ww(OFS_CLRT + 8'h4, 32'hffffffff, 4'h2);
      rchk(OFS_CLRT, 32'h00002e0a);
      ww(OFS_CLRT, 32'hffff1203, STRB_HIGH);
      rchk(OFS_CLRT, 32'h00002e0a);
   endtask : t_alias
   // retry limit of two: two retries, then abort; limit zero aborts at once
   task automatic t_retry();
      logic rt, ab;
      ww(OFS_CLRT, 32'h00003702, STRB_LOW);
      mac_tx_mgmt_model_i.new_frame();
      for (int k = 0; k < 3; k++) begin
         mac_tx_mgmt_model_i.collide(rt, ab);
         chk({rt, ab}, (k < 2) ? 32'h2 : 32'h1);
      end
      ww(OFS_CLRT, 32'h00003700, STRB_WORD);
      mac_tx_mgmt_model_i.new_frame();
      mac_tx_mgmt_model_i.collide(rt, ab);
      chk({rt, ab}, 32'h1);
   endtask : t_retry
   // mgmt indicators and link failure
   task automatic t_mind();
      mac_tx_mgmt_model_i.mgmt(3'b101);
      rchk(OFS_MIND, 32'h5);
      mac_tx_mgmt_model_i.mgmt(3'b010);
      rchk(OFS_MIND, 32'h2);
      mac_tx_mgmt_model_i.phy_status(1'b1);
      rchk(OFS_MIND, 32'ha);
      mac_tx_mgmt_model_i.mgmt(3'b000);
      mac_tx_mgmt_model_i.phy_status(1'b0);
      rchk(OFS_MIND, 32'h0);
   endtask : t_mind
   // interrupt raised, cleared, masked; unmapped place refused
   task automatic t_irq();
      logic [31:0] d;
      logic [1:0] r;
      ww(OFS_IRQ_STAT, 32'h7, STRB_WORD);
      ww(OFS_IRQ_MASK, 32'h1, STRB_WORD);
      mac_tx_mgmt_model_i.frame_done();
      repeat (3) @(posedge clock);
      #1 chk(irq, 1'b1);
      ww(OFS_IRQ_STAT, 32'h1, STRB_WORD);
      repeat (3) @(posedge clock);
      #1 chk(irq, 1'b0);
      ww(OFS_IRQ_MASK, 32'h0, STRB_WORD);
      mac_tx_mgmt_model_i.frame_done();
      repeat (3) @(posedge clock);
      #1 chk(irq, 1'b0);
      rchk(OFS_IRQ_STAT, 32'h1);
      wr(8'h38, 32'h1, STRB_WORD, r);
      chk(r, RESP_SLVERR);
      rd(8'h3c, d, r);
      chk({d[29:0], r}, {30'h0, RESP_SLVERR});
   endtask : t_irq
   // reset, then the scenarios in turn
   initial begin
      rst_b = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      n_fail = 0;
      check_count = 0;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset();
      t_count();
      t_alias();
      t_retry();
      t_mind();
      t_irq();
      test_done();
   end
endmodule : mac_coll_mgmt_regs_test
`default_nettype wire
